/* File: tcm_pkg.sv */
package tcm_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int unsigned TCM_LBL_W = 15;
    localparam int unsigned TCM_BCNT_W = 4;
    localparam int unsigned TCM_U_W = 30;
    localparam int unsigned TCM_CRD_W = 8;
    localparam int unsigned TCM_OUT_W = 16;
    localparam int unsigned TCM_REF_W = 9;
    localparam int unsigned TCM_SCL_W = 15;
    localparam int unsigned TCM_CNT_W = 10;

    // ----------------------------------------------------------------
    // Constellation limits and scaling
    // ----------------------------------------------------------------
    localparam int unsigned TCM_MAXB_DEF = 15;
    localparam int unsigned TCM_MAXB_LO = 8;
    localparam int unsigned TCM_MAXB_HI = 15;
    localparam logic [3:0] TCM_B_FILL = 4'h2;
    // Reference level is unsigned with this many fraction bits
    localparam int unsigned TCM_REF_SHIFT = 8;
    // Q14 factors giving unit rms energy for square b-bit grids
    localparam logic [14:0] TCM_SCL_B2 = 15'h2d41;
    localparam logic [14:0] TCM_SCL_B4 = 15'h143d;
    localparam logic [14:0] TCM_SCL_B6 = 15'h09e0;
    localparam logic [14:0] TCM_SCL_B8 = 15'h04e9;
    localparam logic [14:0] TCM_SCL_B10 = 15'h0273;
    localparam logic [14:0] TCM_SCL_B12 = 15'h013a;
    localparam logic [14:0] TCM_SCL_B14 = 15'h009d;

    // ----------------------------------------------------------------
    // Filler sequence and encoder
    // ----------------------------------------------------------------
    localparam int unsigned TCM_PRBS_LEN = 23;
    localparam int unsigned TCM_PRBS_TAP = 18;
    localparam logic [22:0] TCM_PRBS_SEED = 23'h7fffff;
    localparam logic [3:0] TCM_ENC_RST = 4'h0;

    typedef enum {TCM_ST_IDLE, TCM_ST_HOLD} tcm_state_e;

endpackage : tcm_pkg

/* File: tcm_prbs.sv */
`timescale 1ns/100ps

module tcm_prbs
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic restart,
    input wire logic step,
    output logic [1:0] fill_bits
);
    import tcm_pkg::*;

    // Holds the next 23 sequence elements, oldest in bit 0
    logic [TCM_PRBS_LEN-1:0] sr_q;
    logic new0;
    logic new1;

    // ----------------------------------------------------------------
    // Two elements per step, each the xor of 18 and 23 places back
    // ----------------------------------------------------------------
    assign new0 = sr_q[TCM_PRBS_LEN-TCM_PRBS_TAP] ^ sr_q[0];
    assign new1 = sr_q[TCM_PRBS_LEN-TCM_PRBS_TAP+1] ^ sr_q[1];
    assign fill_bits = sr_q[1:0];

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sr_q <= TCM_PRBS_SEED;
        else if (restart)
            sr_q <= TCM_PRBS_SEED;
        else if (step)
            sr_q <= {new1, new0, sr_q[TCM_PRBS_LEN-1:2]};
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_prbs_restart;
        restart |=> sr_q == TCM_PRBS_SEED;
    endproperty
    a_prbs_restart: assert property (p_prbs_restart)
        else $error("filler sequence not reloaded");

    property p_prbs_recur;
        step && !restart |=> sr_q[22:21] == $past({new1, new0});
    endproperty
    a_prbs_recur: assert property (p_prbs_recur)
        else $error("filler recurrence broken");

endmodule : tcm_prbs

/* File: tcm_mapper.sv */
`timescale 1ns/100ps

// Overview of operation
// - First coset pair v1 = u3 xor u1, v0 = u3.
// - Second coset pair w1 = xor of u3..u0, w0 = u3 xor u2.
// - u2..u0 pick the 4-D coset, u3 picks its Cartesian product.
// - u0 equals encoder state bit S0; u2, u1 choose the branch.
// - Two label LSBs of each point equal its 2-D coset index.
// - Maximum bits per tone is 8 to 15; any count up to it allowed; here odd counts are flagged unsupported.
// - Tones taken in reordered order, counts per allocation, LSB first.
// - Loaded active tone takes b bits, first bit becomes label LSB.
// - Two-bit tone points 0..3 follow (v1,v0) 00, 01, 10, 11.
// - Scale grid so every size carries the reference rms energy.
// - Unloaded active tone takes 2 filler bits, maps as two-bit point.
// - Pilot with format flag set takes 2 filler bits, no data.
// - Unloaded tone outside the set takes no bits, any point allowed.
// - Filler starts with 23 ones, then xor of 18 and 23 back.
// - Filler restarts at data mode and each low-power exit.
// - Per data symbol draw twice the unloaded active tone count.
// - Filler never advances in sync or low-power exit symbols.
// - Even b: X from odd label bits, Y from even, then a 1.
// - Encoder state clears to zero at each symbol start.
// - Last two 4-D symbols force u1 = S1 xor S3, u2 = S2.
// - Label v is mapped before label w for each pair with nonzero pair_x; with pair_x zero only w is mapped.
module tcm_mapper
#(
    parameter int unsigned MAX_BITS = tcm_pkg::TCM_MAXB_DEF
)
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sym_start,
    input wire logic sym_is_data,
    input wire logic prbs_restart,
    input wire logic pilot_format_flag,
    input wire logic [tcm_pkg::TCM_REF_W-1:0] reference_transmit_level,
    input wire logic pair_valid,
    output logic pair_ready,
    input wire logic [tcm_pkg::TCM_U_W-1:0] pair_u,
    input wire logic [tcm_pkg::TCM_BCNT_W-1:0] pair_x,
    input wire logic [tcm_pkg::TCM_BCNT_W-1:0] pair_y,
    input wire logic pair_last2,
    input wire logic tone_valid,
    output logic tone_ready,
    input wire logic [tcm_pkg::TCM_BCNT_W-1:0] tone_bits,
    input wire logic tone_in_set,
    input wire logic tone_pilot,
    output logic point_valid,
    input wire logic point_ready,
    output logic [tcm_pkg::TCM_OUT_W-1:0] point_x,
    output logic [tcm_pkg::TCM_OUT_W-1:0] point_y,
    output logic [tcm_pkg::TCM_CRD_W-1:0] point_grid_x,
    output logic [tcm_pkg::TCM_CRD_W-1:0] point_grid_y,
    output logic [tcm_pkg::TCM_BCNT_W-1:0] point_bits,
    output logic point_pilot,
    output logic point_offgrid,
    output logic point_unsupported,
    output logic [tcm_pkg::TCM_CNT_W-1:0] prbs_bits_drawn,
    output logic [3:0] enc_state
);
    import tcm_pkg::*;

    // ----------------------------------------------------------------
    // Functions
    // ----------------------------------------------------------------

    // Copies n-2 upper label bits from u, starting at u index k+off
    function automatic logic [TCM_LBL_W-1:0] take_bits
    (
        input logic [TCM_U_W-1:0] u,
        input logic [4:0] off,
        input logic [TCM_BCNT_W-1:0] n
    );
        logic [TCM_LBL_W-1:0] r;
        r = '0;
        for (int k = 2; k < TCM_LBL_W; k++)
        begin
            if (k < int'(n) && (k + int'(off)) < TCM_U_W)
                r[k] = u[k+int'(off)];
        end
        return r;
    endfunction : take_bits

    // Odd-integer axis value; sel 0 gives X (odd bits), 1 gives Y
    function automatic logic [TCM_CRD_W-1:0] map_axis
    (
        input logic [TCM_LBL_W-1:0] lbl,
        input logic [TCM_BCNT_W-1:0] b,
        input logic sel
    );
        logic [TCM_CRD_W-1:0] r;
        int half;
        r = 8'h01;
        half = int'(b) / 2;
        for (int i = 0; i < TCM_CRD_W - 1; i++)
        begin
            if (i < half)
                r[i+1] = lbl[2*i+(sel ? 0 : 1)];
        end
        for (int j = 1; j < TCM_CRD_W; j++)
        begin
            if (j > half)
                r[j] = r[half];
        end
        return r;
    endfunction : map_axis

    function automatic logic [TCM_SCL_W-1:0] scale_q14
    (
        input logic [TCM_BCNT_W-1:0] b
    );
        unique case (b)
            4'h2: return TCM_SCL_B2;
            4'h4: return TCM_SCL_B4;
            4'h6: return TCM_SCL_B6;
            4'h8: return TCM_SCL_B8;
            4'ha: return TCM_SCL_B10;
            4'hc: return TCM_SCL_B12;
            4'he: return TCM_SCL_B14;
            default: return '0;
        endcase
    endfunction : scale_q14

    // Grid value times size factor times reference level
    function automatic logic [TCM_OUT_W-1:0] scale_pt
    (
        input logic [TCM_CRD_W-1:0] crd,
        input logic [TCM_BCNT_W-1:0] b,
        input logic [TCM_REF_W-1:0] lvl
    );
        logic signed [33:0] p;
        logic signed [33:0] s;
        p = 34'(signed'(crd)) * 34'(signed'({1'b0, scale_q14(b)}))
            * 34'(signed'({1'b0, lvl}));
        s = p >>> (TCM_REF_SHIFT + 14);
        return s[TCM_OUT_W-1:0];
    endfunction : scale_pt

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    tcm_state_e st_q;
    logic [3:0] enc_q;
    logic [3:0] enc_eff;
    logic [3:0] enc_nxt;
    logic [TCM_U_W-1:0] u_eff;
    logic [1:0] v10;
    logic [1:0] w10;
    logic [TCM_LBL_W-1:0] lbl_v;
    logic [TCM_LBL_W-1:0] lbl_w;
    logic [TCM_LBL_W-1:0] w_q;
    logic have_w_q;
    logic [TCM_LBL_W-1:0] lbl_sel;
    logic [TCM_BCNT_W-1:0] b_eff;
    logic sym_data_q;
    logic sym_data_eff;
    logic need_lbl;
    logic fill;
    logic bad_b;
    logic tone_take;
    logic pair_take;
    logic [1:0] fill_bits;
    logic [TCM_CNT_W-1:0] drawn_q;
    logic [TCM_LBL_W-1:0] lbl_q;
    logic [1:0] cos_v_q;
    logic [1:0] cos_w_q;
    logic [4:0] w_off;

    // ----------------------------------------------------------------
    // Trellis word to coset labels
    // ----------------------------------------------------------------
    always_comb
    begin
        // A symbol start in the same cycle as a pair uses the clear state
        enc_eff = sym_start ? TCM_ENC_RST : enc_q;
        u_eff = pair_u;
        u_eff[0] = enc_eff[0];
        if (pair_last2)
        begin
            u_eff[1] = enc_eff[1] ^ enc_eff[3];
            u_eff[2] = enc_eff[2];
        end
        // u3 picks the product, u2..u0 the 4-D coset
        v10 = {u_eff[3] ^ u_eff[1], u_eff[3]};
        w10 = {u_eff[3] ^ u_eff[2] ^ u_eff[1] ^ u_eff[0],
               u_eff[3] ^ u_eff[2]};
        enc_nxt = {enc_eff[1], enc_eff[0],
                   enc_eff[1] ^ enc_eff[3] ^ u_eff[1],
                   enc_eff[2] ^ u_eff[2]};
        // With no v tone the w bits start right above u3
        w_off = (pair_x == '0) ? 5'h02 : {1'b0, pair_x};
        lbl_v = take_bits(u_eff, 5'h02, pair_x);
        lbl_v[1:0] = v10;
        if (pair_x == '0)
            lbl_v = '0;
        lbl_w = take_bits(u_eff, w_off, pair_y);
        lbl_w[1:0] = w10;
    end

    // ----------------------------------------------------------------
    // Tone classification and handshakes
    // ----------------------------------------------------------------
    assign sym_data_eff = sym_start ? sym_is_data : sym_data_q;
    assign need_lbl = tone_bits != '0;
    // Filler only in data symbols, for active or flagged pilot tones
    assign fill = !need_lbl && sym_data_eff
                  && (tone_in_set || (tone_pilot && pilot_format_flag));
    // Odd sizes are not built here; they are flagged instead
    assign bad_b = need_lbl
                   && (tone_bits[0] || int'(tone_bits) > MAX_BITS);
    assign tone_ready = (st_q == TCM_ST_IDLE)
                        && (!need_lbl || have_w_q || pair_valid);
    assign pair_ready = (st_q == TCM_ST_IDLE) && tone_valid && need_lbl
                        && !have_w_q;
    assign tone_take = tone_valid && tone_ready;
    assign pair_take = pair_valid && pair_ready;
    assign point_valid = st_q == TCM_ST_HOLD;
    assign prbs_bits_drawn = drawn_q;
    assign enc_state = enc_q;

    always_comb
    begin
        b_eff = tone_bits;
        lbl_sel = '0;
        if (fill)
        begin
            b_eff = TCM_B_FILL;
            lbl_sel = {13'h0000, fill_bits};
        end
        else if (have_w_q)
            lbl_sel = w_q;
        else if (pair_x == '0)
            lbl_sel = lbl_w;
        else
            lbl_sel = lbl_v;
    end

    // ----------------------------------------------------------------
    // Filler sequence
    // ----------------------------------------------------------------
    tcm_prbs u_prbs
    (
        .mclk(mclk),
        .rst_b(rst_b),
        .restart(prbs_restart),
        .step(tone_take && fill),
        .fill_bits(fill_bits)
    );

    // ----------------------------------------------------------------
    // State registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= TCM_ST_IDLE;
        else
        begin
            unique case (st_q)
                TCM_ST_IDLE:
                    if (tone_take)
                        st_q <= TCM_ST_HOLD;
                TCM_ST_HOLD:
                    if (point_ready)
                        st_q <= TCM_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            enc_q <= TCM_ENC_RST;
        else if (pair_take)
            enc_q <= enc_nxt;
        else if (sym_start)
            enc_q <= TCM_ENC_RST;
    end

    // The w label waits for the next loaded tone in reordered order
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            have_w_q <= 1'b0;
            w_q <= '0;
        end
        else if (pair_take)
        begin
            have_w_q <= pair_x != '0;
            w_q <= lbl_w;
        end
        else if (tone_take && need_lbl)
            have_w_q <= 1'b0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sym_data_q <= 1'b0;
            drawn_q <= '0;
        end
        else
        begin
            if (sym_start)
                sym_data_q <= sym_is_data;
            if (sym_start)
                drawn_q <= (tone_take && fill) ? 10'h002 : 10'h000;
            else if (tone_take && fill)
                drawn_q <= drawn_q + 10'h002;
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cos_v_q <= 2'h0;
            cos_w_q <= 2'h0;
        end
        else if (pair_take)
        begin
            cos_v_q <= v10;
            cos_w_q <= w10;
        end
    end

    // ----------------------------------------------------------------
    // Point output registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            point_x <= '0;
            point_y <= '0;
            point_grid_x <= '0;
            point_grid_y <= '0;
            point_bits <= '0;
            point_pilot <= 1'b0;
            point_offgrid <= 1'b0;
            point_unsupported <= 1'b0;
            lbl_q <= '0;
        end
        else if (tone_take)
        begin
            point_bits <= b_eff;
            lbl_q <= lbl_sel;
            // Modulator overwrites flagged pilot points
            point_pilot <= tone_pilot && pilot_format_flag && fill;
            // Unloaded tone with no filler (outside the set, or not a data symbol) sends a zero point, no bits taken
            point_offgrid <= !need_lbl && !fill;
            point_unsupported <= bad_b;
            if (bad_b || (!need_lbl && !fill))
            begin
                point_x <= '0;
                point_y <= '0;
                point_grid_x <= '0;
                point_grid_y <= '0;
            end
            else
            begin
                // First bit of the tone is label LSB, v0 for a v tone or w0 for a w tone
                point_grid_x <= map_axis(lbl_sel, b_eff, 1'b0);
                point_grid_y <= map_axis(lbl_sel, b_eff, 1'b1);
                point_x <= scale_pt(map_axis(lbl_sel, b_eff, 1'b0),
                                    b_eff, reference_transmit_level);
                point_y <= scale_pt(map_axis(lbl_sel, b_eff, 1'b1),
                                    b_eff, reference_transmit_level);
            end
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    property p_v_coset;
        pair_take |=> cos_v_q == {$past(u_eff[3] ^ u_eff[1]),
                                  $past(u_eff[3])};
    endproperty
    a_v_coset: assert property (p_v_coset)
        else $error("v coset bits wrong");

    property p_w_coset;
        pair_take |=> cos_w_q[0] == $past(u_eff[3] ^ u_eff[2])
                      && cos_w_q[1] == $past(^u_eff[3:0]);
    endproperty
    a_w_coset: assert property (p_w_coset)
        else $error("w coset bits wrong");

    property p_u0_state;
        pair_take |-> u_eff[0] == enc_q[0] || sym_start;
    endproperty
    a_u0_state: assert property (p_u0_state)
        else $error("u0 differs from state");

    property p_sym_clear;
        sym_start && !pair_take |=> enc_q == 4'h0;
    endproperty
    a_sym_clear: assert property (p_sym_clear)
        else $error("encoder state not cleared");

    // Forced pairs taken since symbol start
    logic [1:0] last2_n_q;
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            last2_n_q <= 2'h0;
        else if (sym_start)
            last2_n_q <= 2'h0;
        else if (pair_take && pair_last2)
            last2_n_q <= last2_n_q + 2'h1;
    end

    property p_term_zero;
        pair_take && pair_last2 && last2_n_q == 2'h1 && !sym_start
        |=> enc_q == 4'h0;
    endproperty
    a_term_zero: assert property (p_term_zero)
        else $error("encoder not terminated");

    property p_lsb_coset;
        $rose(point_valid) && !point_offgrid && !point_unsupported
        |-> point_grid_x[1] == lbl_q[1] && point_grid_y[1] == lbl_q[0];
    endproperty
    a_lsb_coset: assert property (p_lsb_coset)
        else $error("label LSBs not on coset");

    property p_fill_two;
        $rose(point_valid) && $past(fill) |-> point_bits == 4'h2
        && drawn_q >= 10'h002;
    endproperty
    a_fill_two: assert property (p_fill_two)
        else $error("filler tone not two bits");

    property p_no_fill_idle;
        !sym_data_eff && !prbs_restart |=> $stable(fill_bits);
    endproperty
    a_no_fill_idle: assert property (p_no_fill_idle)
        else $error("filler drawn outside data symbol");

    property p_pilot;
        point_pilot && point_valid |-> point_bits == 4'h2
        && lbl_q[14:2] == 13'h0000;
    endproperty
    a_pilot: assert property (p_pilot)
        else $error("pilot point malformed");

    property p_hold;
        point_valid && !point_ready |=> point_valid && $stable(point_x);
    endproperty
    a_hold: assert property (p_hold)
        else $error("point dropped before taken");

    c_pair_x0: cover property (pair_take && pair_x == 4'h0);
    c_fill: cover property (tone_take && fill);
    c_offgrid: cover property ($rose(point_valid) && point_offgrid);
    c_v_then_w: cover property (pair_take ##[1:4] tone_take && have_w_q);

endmodule : tcm_mapper

/* File: tcm_sink.sv */
`timescale 1ns/100ps

// ------------------------------------------------------------
// Gain stage model: takes points, stalling at random
// ------------------------------------------------------------
module tcm_sink
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic point_valid,
    output logic point_ready
);
    int seed_q = 32'h1b5e0a37;

    // Stalls make the mapper hold each point for a while
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            point_ready <= 1'b0;
        else
            point_ready <= point_valid && ($random(seed_q) % 3 != 0);
    end
endmodule : tcm_sink

/* File: test_tcm_mapper.sv */
`timescale 1ns/100ps

module test_tcm_mapper;
    import tcm_pkg::*;

    localparam int MAXB = 8;
    logic mclk, rst_b, sym_start, sym_is_data, prbs_restart, data_q;
    logic pilot_format_flag, pair_valid, pair_ready, pair_last2;
    logic tone_valid, tone_ready, tone_in_set, tone_pilot;
    logic point_valid, point_ready, point_pilot, point_offgrid;
    logic point_unsupported;
    logic [8:0] rtl;
    logic [29:0] pair_u;
    logic [3:0] pair_x, pair_y, tone_bits, point_bits, enc_state, st;
    logic [15:0] point_x, point_y;
    logic [7:0] point_grid_x, point_grid_y;
    logic [9:0] prbs_bits_drawn, drawn;
    logic [22:0] prbs;
    logic [3:0] sz [8] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h6, 4'h8, 4'ha, 4'he};
    int seed = 32'h3fa2cd10;
    int n_mismatch = 0;
    int n_checks = 0;

    tcm_mapper #(.MAX_BITS(MAXB)) i_dut
    (
        .mclk(mclk), .rst_b(rst_b), .sym_start(sym_start),
        .sym_is_data(sym_is_data), .prbs_restart(prbs_restart),
        .pilot_format_flag(pilot_format_flag),
        .reference_transmit_level(rtl), .pair_valid(pair_valid),
        .pair_ready(pair_ready), .pair_u(pair_u), .pair_x(pair_x),
        .pair_y(pair_y), .pair_last2(pair_last2), .tone_valid(tone_valid),
        .tone_ready(tone_ready), .tone_bits(tone_bits),
        .tone_in_set(tone_in_set), .tone_pilot(tone_pilot),
        .point_valid(point_valid), .point_ready(point_ready),
        .point_x(point_x), .point_y(point_y), .point_grid_x(point_grid_x),
        .point_grid_y(point_grid_y), .point_bits(point_bits),
        .point_pilot(point_pilot), .point_offgrid(point_offgrid),
        .point_unsupported(point_unsupported),
        .prbs_bits_drawn(prbs_bits_drawn), .enc_state(enc_state)
    );

    tcm_sink i_sink
    (
        .mclk(mclk), .rst_b(rst_b), .point_valid(point_valid),
        .point_ready(point_ready)
    );

    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Reference models
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : finish_test

    task automatic chk(input string nm, input logic [15:0] e, g);
        n_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Window holds the next 23 outputs, oldest in bit 0
    function automatic logic pop();
        logic b;
        b = prbs[0];
        prbs = {prbs[5] ^ prbs[0], prbs[22:1]};
        return b;
    endfunction : pop

    function automatic logic [7:0] grid(input logic [14:0] l,
                                        input int b, input int sx);
        int g, i;
        g = 0;
        for (i = b - 2 + sx; i >= 0; i -= 2)
            g = g * 2 + int'(l[i]);
        g = g * 2 + 1 - (int'(l[b - 2 + sx]) << (b / 2 + 1));
        return 8'(g);
    endfunction : grid

    function automatic logic [15:0] scl(input logic [7:0] g,
                                        input logic [3:0] b);
        logic [14:0] f;
        case (b)
            4'h2: f = TCM_SCL_B2;
            4'h4: f = TCM_SCL_B4;
            4'h6: f = TCM_SCL_B6;
            default: f = TCM_SCL_B8;
        endcase
        return 16'((longint'($signed(g)) * longint'(f) * longint'(rtl)) >>> 22);
    endfunction : scl

    function automatic int mk(input logic [3:0] b);
        return (b[0] || b > MAXB) ? 2 : 0;
    endfunction : mk

    task automatic new_sym(input logic data, input logic rs);
        @(posedge mclk);
        sym_start <= 1'b1;
        sym_is_data <= data;
        prbs_restart <= rs;
        pilot_format_flag <= 1'($random(seed));
        rtl <= 9'($random(seed));
        @(posedge mclk);
        sym_start <= 1'b0;
        prbs_restart <= 1'b0;
        data_q = data;
        drawn = '0;
        st = '0;
        if (rs)
            prbs = '1;
        @(negedge mclk);
        chk("enc_state", 16'(st), 16'(enc_state));
        chk("drawn", 16'(drawn), 16'(prbs_bits_drawn));
        $display("symbol started, checks %0d", n_checks);
    endtask : new_sym

    task automatic tone(input logic [3:0] b, input logic ins, pil, pv, l2,
                        input logic [29:0] u, input logic [3:0] x, y,
                        input logic [14:0] lbl, input logic [3:0] eb,
                        input int kind);
        logic [7:0] gx, gy;
        int k;
        gx = kind == 0 ? grid(lbl, eb, 1) : 8'h00;
        gy = kind == 0 ? grid(lbl, eb, 0) : 8'h00;
        @(posedge mclk);
        tone_valid <= 1'b1;
        tone_bits <= b;
        tone_in_set <= ins;
        tone_pilot <= pil;
        pair_valid <= pv;
        pair_u <= u;
        pair_x <= x;
        pair_y <= y;
        pair_last2 <= l2;
        @(negedge mclk);
        for (k = 0; k < 50 && tone_ready !== 1'b1; k++)
            @(negedge mclk);
        chk("pair_ready", 16'(pv), 16'(pair_ready));
        @(posedge mclk);
        tone_valid <= 1'b0;
        pair_valid <= 1'b0;
        @(negedge mclk);
        chk("point_valid", 16'h1, 16'(point_valid));
        chk("grid_x", 16'(gx), 16'(point_grid_x));
        chk("grid_y", 16'(gy), 16'(point_grid_y));
        chk("flags", 16'({kind == 1, kind == 2, pil && pilot_format_flag}),
            16'({point_offgrid, point_unsupported, point_pilot}));
        chk("drawn", 16'(drawn), 16'(prbs_bits_drawn));
        chk("enc_state", 16'(st), 16'(enc_state));
        chk("point_x", scl(gx, eb), point_x);
        chk("point_y", scl(gy, eb), point_y);
        if (kind == 0)
        begin
            chk("bits", 16'(eb), 16'(point_bits));
        end
        for (k = 0; k < 50 && point_ready !== 1'b1; k++)
            @(negedge mclk);
        @(posedge mclk);
    endtask : tone

    task automatic fill(input logic ins, pil);
        logic [14:0] l;
        logic f;
        l = '0;
        f = data_q && (ins || (pil && pilot_format_flag));
        if (f)
        begin
            l[0] = pop();
            l[1] = pop();
            drawn += 10'h2;
        end
        tone(4'h0, ins, pil, 1'b0, 1'b0, '0, '0, '0, l, 4'h2,
             f ? 0 : 1);
    endtask : fill

    task automatic pair(input logic [3:0] x, y, input logic l2);
        logic [29:0] u;
        logic [3:0] uu;
        logic [14:0] v, w;
        int k, o;
        u = 30'({$random(seed), $random(seed)});
        if (x == 0)
            u[3:1] = {1'b0, u[2], 1'b0};
        uu = {u[3], l2 ? st[2] : u[2], l2 ? st[1] ^ st[3] : u[1], st[0]};
        o = x == 0 ? 2 : int'(x);
        v = '0;
        w = '0;
        for (k = 2; k < 15; k++)
        begin
            v[k] = k < x ? u[k + 2] : 1'b0;
            w[k] = k < y ? u[k + o] : 1'b0;
        end
        v[1:0] = {uu[3] ^ uu[1], uu[3]};
        w[1:0] = {^uu, uu[3] ^ uu[2]};
        st = {st[1], st[0], st[1] ^ st[3] ^ uu[1], st[2] ^ uu[2]};
        if (x != 0)
            tone(x, 1'b1, 1'b0, 1'b1, l2, u, x, y, v, x, mk(x));
        tone(y, 1'b1, 1'b0, x == 0, x == 0 && l2, u, x, y, w, y, mk(y));
    endtask : pair

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        int i;
        {sym_start, sym_is_data, prbs_restart, pair_valid} = '0;
        {pair_last2, tone_valid, tone_in_set, tone_pilot, data_q} = '0;
        {pair_u, pair_x, pair_y, tone_bits, st, drawn} = '0;
        pilot_format_flag = 1'b1;
        rtl = 9'h100;
        prbs = '1;
        rst_b = 1'b0;
        repeat (20) @(posedge mclk);
        rst_b <= 1'b1;
        new_sym(1'b1, 1'b1);
        for (i = 0; i < 60; i++)
        begin
            case ($unsigned($random(seed)) % 5)
                0: fill(1'b1, 1'b0);
                1: fill(1'b0, 1'b1);
                2: fill(1'b0, 1'b0);
                default: pair(sz[$unsigned($random(seed)) % 8],
                              sz[1 + $unsigned($random(seed)) % 7], 1'b0);
            endcase
            if (i % 30 == 14)
            begin
                pair(4'h2, 4'h4, 1'b1);
                pair(4'h6, 4'h2, 1'b1);
                chk("enc_end", 16'h0, 16'(enc_state));
            end
            if (i % 15 == 14)
            begin
                new_sym(1'b0, 1'b0);
                fill(1'b1, 1'b0);
                new_sym(1'b1, i == 29);
            end
        end
        finish_test;
    end

    // Whole run needs a few hundred cycles; this is ample
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        finish_test;
    end
endmodule : test_tcm_mapper
